// ---- bench/bdc_host_model.sv ----
// Host model that drives the control pin of the dimming block
// Assumes the bench forms the open-drain wire from drv_o and the ack
`timescale 1ns/100ps

module bdc_host_model (
  // Clock
  input wire logic clk_i,
  // Pin drive, high releases the line
  output logic drv_o
);
  // Line held low at start, so the device is off
  initial drv_o = 1'b0;

  // Hold a level for n cycles, changed just after an edge
  task automatic hold(input logic lvl, input int n);
    @(posedge clk_i);
    drv_o <= lvl;
    repeat (n - 1) @(posedge clk_i);
  endtask : hold

  // Entry pattern: high past the delay, then a long low
  task automatic enter_single(input int dly, input int low);
    hold(1'b1, dly);
    hold(1'b0, low);
    hold(1'b1, 1);
  endtask : enter_single

  // Address byte then data byte, MSB first; ends in end-of-stream low
  task automatic send_frame(input logic [15:0] f, input int k);
    for (int i = 15; i >= 0; i--)
    begin
      hold(1'b0, f[i] ? k : 2 * k);
      hold(1'b1, f[i] ? 2 * k : k);
    end
    hold(1'b0, 76); // Long enough to end the stream, short of shutdown
  endtask : send_frame

  // Duty-cycle dimming at 100 kHz, period of 200 cycles
  task automatic pwm(input int hi, input int n);
    repeat (n)
    begin
      hold(1'b1, hi);
      hold(1'b0, 200 - hi);
    end
  endtask : pwm
endmodule : bdc_host_model

// ---- bench/bdc_top_test.sv ----
// Self-checking bench of the backlight dimming control block
// Assumes the host model on the pin and an open-drain wire with pull-up
`timescale 1ns/100ps

module bdc_top_test
  import bdc_pkg::*;
;
  logic clk_i;
  logic rst_i;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [3:0] wb_adr;
  logic [31:0] wb_wdat;
  logic [3:0] wb_sel;
  logic [31:0] wb_rdat;
  logic wb_ack;
  logic ctrl_oe;
  logic ctrl_out;
  logic host_drv;
  logic ok;
  wire logic ctrl_line;
  bdc_ana_s ana;
  bdc_pwr_s pwr;
  bdc_ref_s rfo;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  logic [31:0] rnd;
  logic [4:0] step;
  logic [15:0] frm;
  logic [7:0] n_cmd;
  logic [7:0] last_dat;
  logic [15:0] frames [10];
  int n_errors;
  int checks_done;
  int hi_cnt;

  // Pull-up wire: low when the host pulls it or the device drives its low level
  assign ctrl_line = host_drv & (~ctrl_oe | ctrl_out);

  // Short counts keep the run brief; the host timings below lean on them
  localparam logic [12:0] SS_STEP = 13'h8;
  localparam logic [16:0] DET_LOW = 17'h14;
  localparam logic [16:0] WIN_LEN = 17'hbb8;
  localparam logic [16:0] SHDN_LEN = 17'hfa0;
  localparam logic [15:0] ACK_LEN = 16'ha;
  localparam logic [15:0] IDLE_LEN = 16'h64;

  bdc_top #(
    .SS_STEP_CYC(SS_STEP),
    .DET_CYC(DET_LOW),
    .WIN_CYC(WIN_LEN),
    .SHDN_CYC(SHDN_LEN),
    .ACK_CYC(ACK_LEN),
    .IDLE_CYC(IDLE_LEN)
  ) u_dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat),
    .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack),
    .ctrl_i(ctrl_line),
    .ctrl_o(ctrl_out),
    .ctrl_oe_o(ctrl_oe),
    .ana_i(ana),
    .pwr_o(pwr),
    .ref_o(rfo)
  );

  bdc_host_model u_host (
    .clk_i(clk_i),
    .drv_o(host_drv)
  );

  // 20 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Random source, fixed start
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // Reference in mV per step code, three slopes
  function automatic logic [7:0] mv_of(input logic [4:0] c);
    if (c == 5'h0)
      return 8'h0;
    if (c <= 5'h0c)
      return 8'(2 + 3 * c);
    if (c <= 5'h17)
      return 8'(38 + 6 * (c - 12));
    return 8'(104 + 12 * (c - 23));
  endfunction : mv_of

  // Value compare
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle; a read notes expected data and mask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    @(posedge clk_i);
    {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
    wb_adr <= a;
    wb_wdat <= d;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    // No limit of its own; a hung slave is caught by the watchdog
    do @(posedge clk_i); while (wb_ack !== 1'b1);
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb

  // Read data against the oldest note; a stale value equal to the note still passes
  always @(posedge clk_i)
    if (wb_ack === 1'b1 && wb_we === 1'b0)
      chk(wb_rdat & msk_q.pop_front(), exp_q.pop_front());

  // Wait n edges, then let their updates land
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict

  // Watchdog, about two and a half times the expected run
  initial
  begin
    #4000000;
    n_errors++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 4'h0;
    wb_wdat = 32'h0;
    wb_sel = 4'hf;
    n_cmd = 8'h0;
    last_dat = 8'h0;
    ana = 2'b00;
    rnd = 32'h243fa7c0;
    frames = '{16'h5880, 16'h580c, 16'h588d, 16'h5817, 16'h5898,
               16'h58a5, 16'h7281, 16'h58c1, 16'h0, 16'h0};
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    tick(1);
    chk(pwr, 3'h0);
    wb(1'b0, 4'h0, 32'h1f01, 32'h1f1f);
    rnd = xs(rnd);
    wb(1'b1, 4'h4, rnd & 32'hfffffffe, 32'h0);
    wb(1'b0, 4'h4, 32'h0, 32'h1);
    wb(1'b1, 4'h4, rnd | 32'h1, 32'h0);
    wb(1'b0, 4'h4, 32'h1, 32'h1);
    // Lane 0 off: the write must leave the enable bit alone
    wb_sel <= {rnd[7:5], 1'b0};
    wb(1'b1, 4'h4, 32'h0, 32'h0);
    wb_sel <= 4'hf;
    wb(1'b0, 4'h4, 32'h1, 32'h1);
    wb(1'b0, 4'hc, 32'h0, 32'hffffffff);
    // Plain enable: ramp, half limit, then duty-cycle mode
    u_host.hold(1'b1, 1);
    tick(2);
    chk(pwr, 3'b110);
    tick(35);
    chk(rfo.code, 5'h4);
    tick(230);
    chk(pwr, 3'b100);
    chk(rfo, {1'b1, 5'h1f, 8'hc8});
    tick(2800);
    wb(1'b0, 4'h0, 32'hc81f04, 32'hff1fff);
    u_host.hold(1'b0, 10);
    chk(rfo.gate, 1'b0);
    // One percent duty: the gate must be high exactly as long as the pin
    fork
      u_host.pwm(2, 10);
      repeat (2010)
      begin
        @(posedge clk_i);
        hi_cnt += int'(rfo.gate);
      end
    join
    chk(hi_cnt, 20);
    u_host.hold(1'b0, 4100);
    chk({pwr, rfo}, 17'h0);
    // Single-wire entry and commands, good and spoiled
    u_host.enter_single(2100, 40);
    u_host.hold(1'b1, 1000);
    wb(1'b0, 4'h0, 32'h1f14, 32'h1f1f);
    step = 5'h1f;
    foreach (frames[i])
    begin
      rnd = xs(rnd);
      frm = (i < 8) ? frames[i] : {8'h58, rnd[7], 2'b00, rnd[12:8]};
      u_host.send_frame(frm, 5 + int'(rnd[3:0]));
      ok = frm[15:8] == 8'h58 && frm[6:5] == 2'b00;
      if (ok)
      begin
        step = frm[4:0];
        last_dat = frm[7:0];
        n_cmd++;
      end
      chk(ctrl_oe, ok & frm[7]);
      chk(rfo.mv, mv_of(step));
      u_host.hold(1'b1, 150);
    end
    // Only the valid commands count and leave their data byte
    wb(1'b0, 4'h8, {16'h0, n_cmd, last_dat}, 32'hffff);
    // Restart without the pattern: mode chosen anew, step kept
    u_host.hold(1'b0, 4100);
    u_host.hold(1'b1, 3400);
    wb(1'b0, 4'h0, {19'h0, step, 8'h04}, 32'h1f1f);
    // Open string: latched off until a long low
    @(posedge clk_i) ana <= 2'b11;
    tick(5);
    chk(pwr, 3'b001);
    wb(1'b0, 4'h0, 32'h48, 32'hff00ff);
    @(posedge clk_i) ana <= 2'b00;
    u_host.hold(1'b0, 100);
    u_host.hold(1'b1, 50);
    chk(pwr.gate_en, 1'b0);
    u_host.hold(1'b0, 4100);
    u_host.hold(1'b1, 3);
    tick(1);
    chk(pwr.gate_en, 1'b1);
    // Reset in mid-run restores full scale
    @(posedge clk_i) rst_i <= 1'b1;
    tick(2);
    @(posedge clk_i) rst_i <= 1'b0;
    tick(1);
    wb(1'b0, 4'h0, 32'h1f00, 32'h1f00);
    tick(2);
    print_verdict();
  end
endmodule : bdc_top_test

// ---- common/bdc_defines.svh ----
// Constants of the backlight dimming control block
// Assumes a 50 ns system clock; times are in ns, counts derived from them
`ifndef BDC_DEFINES_SVH
`define BDC_DEFINES_SVH
`define BDC_CLK_NS 50
`define BDC_CYC(ns) (((ns) + `BDC_CLK_NS - 1) / `BDC_CLK_NS)
`define BDC_SS_STEP_NS 341000
`define BDC_DLY_NS 100000
`define BDC_DET_NS 450000
`define BDC_WIN_NS 3500000
`define BDC_SHDN_NS 3500000
`define BDC_EOS_NS 3500
`define BDC_ACK_NS 500000
`define BDC_IDLE_NS 1200000
`define BDC_SS_STEP_CYC `BDC_CYC(`BDC_SS_STEP_NS)
`define BDC_DLY_CYC `BDC_CYC(`BDC_DLY_NS)
`define BDC_DET_CYC `BDC_CYC(`BDC_DET_NS)
`define BDC_WIN_CYC `BDC_CYC(`BDC_WIN_NS)
`define BDC_SHDN_CYC `BDC_CYC(`BDC_SHDN_NS)
`define BDC_EOS_CYC `BDC_CYC(`BDC_EOS_NS)
`define BDC_ACK_CYC `BDC_CYC(`BDC_ACK_NS)
`define BDC_IDLE_CYC `BDC_CYC(`BDC_IDLE_NS)
// Soft start and step code
`define BDC_SS_DONE 6'h20
`define BDC_FULL_CODE 5'h1f
`define BDC_SEG1_END 5'h0c
`define BDC_SEG2_END 5'h17
`define BDC_MV_SLOPE1 8'h03
`define BDC_MV_OFS1 8'h02
`define BDC_MV_SLOPE2 8'h06
`define BDC_MV_OFS2 8'h22
`define BDC_MV_SLOPE3 8'h0c
`define BDC_MV_OFS3 8'hac
// Command frame
`define BDC_DEV_ADDR 8'h58
`define BDC_FRAME_BITS 5'h10
`define BDC_ACK_REQ_POS 7
`define BDC_SUB_ADDR_LO 5
`define BDC_SUB_ADDR_HI 6
// Register offsets, fields and reset values
`define BDC_REG_STATUS 4'h0
`define BDC_REG_CFG 4'h4
`define BDC_REG_CMD 4'h8
`define BDC_CFG_ACK_EN_POS 0
`define BDC_CFG_ACK_EN_RST 1'b1
`endif

// ---- common/bdc_pkg.sv ----
// Types of the backlight dimming control block
// Shared by the design and the bench
package bdc_pkg;
  // One-hot operating states
  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_DET = 4'h2,
    ST_RUN = 4'h4,
    ST_FLT = 4'h8
  } bdc_state_e;

  // Analog comparator results
  typedef struct packed {
    logic overvoltage_trip;
    logic feedback_node_low;
  } bdc_ana_s;

  // Power stage controls
  typedef struct packed {
    logic gate_en;
    logic ilim_half;
    logic ilim_open;
  } bdc_pwr_s;

  // Reference generator controls
  typedef struct packed {
    logic gate;
    logic [4:0] code;
    logic [7:0] mv;
  } bdc_ref_s;
endpackage : bdc_pkg

// ---- design/bdc_top.sv ----
// Digital control of a boost LED backlight driver, one control pin
// Assumes ctrl_i synchronous to clk_i and comparator inputs already clean
//
// Notes on behaviour
// - after enable the reference ramps in 32 equal stages of 341 us.
// - during the ramp the switch current limit is halved.
// - overvoltage plus low feedback node stops switching and shuts down.
// - while the open-string condition holds, the 0.3 A limit is selected.
// - after a fault, stay off until low 3.5 ms then high.
// - control low longer than 3.5 ms means shutdown.
// - in shutdown the switch gate stays inactive.
// - mode decided on each enable; duty-cycle unless pattern seen.
// - first rising edge from shutdown enables and opens 3.5 ms window.
// - single-wire only if low over 450 us after delay, inside window.
// - chosen mode stays until shutdown and a new enable.
// - duty-cycle mode with control high gives full 200 mV.
// - duty-cycle mode gates the 200 mV reference by control level.
// - duty cycles down to 1 percent are followed.
// - one single-wire command sets any of 32 steps by 5-bit code.
// - step register starts at full scale and holds the last step.
// - power-on reset returns the step register to full scale.
// - step table: 0, 5, +3 to 38, +6 to 104, +12 to 200 mV.
// - command is address byte then data byte with zero sub-address.
// - acknowledge only when requested and the command was correct.
// - bit decoding is rate independent, 1.1 to 100 kbit/s.
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/100ps
`include "bdc_defines.svh"

module bdc_top
  import bdc_pkg::*;
#(
  parameter logic [12:0] SS_STEP_CYC = 13'(`BDC_SS_STEP_CYC),
  parameter logic [16:0] DET_CYC = 17'(`BDC_DET_CYC),
  parameter logic [16:0] WIN_CYC = 17'(`BDC_WIN_CYC),
  parameter logic [16:0] SHDN_CYC = 17'(`BDC_SHDN_CYC),
  parameter logic [15:0] ACK_CYC = 16'(`BDC_ACK_CYC),
  parameter logic [15:0] IDLE_CYC = 16'(`BDC_IDLE_CYC)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control pin, open drain
  input wire logic ctrl_i,
  output logic ctrl_o,
  output logic ctrl_oe_o,
  // Analog side
  input wire bdc_ana_s ana_i,
  output bdc_pwr_s pwr_o,
  output bdc_ref_s ref_o
);
  localparam logic [16:0] DLY_CYC = 17'(`BDC_DLY_CYC);
  localparam logic [15:0] EOS_CYC = 16'(`BDC_EOS_CYC);

  bdc_state_e st_q, st_d;
  logic ctrl_q, sw_mode_q, arm_q, ack_q, have_low_q, cfg_ack_en_q, wb_ack_q;
  logic [16:0] low_cnt_q, win_cnt_q;
  logic [12:0] ss_cnt_q;
  logic [5:0] ramp_q;
  logic [4:0] step_q, nbits_q;
  logic [15:0] hi_cnt_q, lo_cnt_q, ack_cnt_q, shift_q;
  logic [7:0] last_data_q, cmd_cnt_q;
  logic [31:0] wb_dat_q;
  bdc_pwr_s pwr_q;
  bdc_ref_s ref_q;

  // Code to millivolt table, three linear segments
  function automatic logic [7:0] code_mv(input logic [4:0] c);
    logic [7:0] w;
    w = {3'h0, c};
    if (c == 5'h00)
      code_mv = 8'h00;
    else if (c <= `BDC_SEG1_END)
      code_mv = w * `BDC_MV_SLOPE1 + `BDC_MV_OFS1;
    else if (c <= `BDC_SEG2_END)
      code_mv = w * `BDC_MV_SLOPE2 - `BDC_MV_OFS2;
    else
      code_mv = w * `BDC_MV_SLOPE3 - `BDC_MV_OFS3;
  endfunction : code_mv

  // Pin edges; our own acknowledge pull-down is masked out
  wire rise = ctrl_i & ~ctrl_q & ~ack_q;
  wire fall = ~ctrl_i & ctrl_q & ~ack_q;
  wire line_low = ~ctrl_i & ~ack_q;
  wire running = (st_q == ST_DET) || (st_q == ST_RUN);
  wire enable = (st_q == ST_OFF) & rise;
  wire shdn_hit = low_cnt_q == SHDN_CYC;
  wire open_now = ana_i.overvoltage_trip & ana_i.feedback_node_low;
  wire win_end = win_cnt_q >= WIN_CYC;
  wire det_hit = (st_q == ST_DET) & arm_q & (low_cnt_q > DET_CYC) & ~win_end;
  wire ss_active = running & (ramp_q != `BDC_SS_DONE);
  wire ss_last = ss_cnt_q == SS_STEP_CYC - 13'h1;

  // Receiver decode and frame check
  wire rx_en = (st_q == ST_RUN) & sw_mode_q & ~ack_q;
  wire bit_val = hi_cnt_q > lo_cnt_q;
  wire eos = rx_en & line_low & ~have_low_q & (nbits_q == `BDC_FRAME_BITS)
             & (lo_cnt_q >= EOS_CYC);
  wire frame_ok = (shift_q[15:8] == `BDC_DEV_ADDR)
                  & ~shift_q[`BDC_SUB_ADDR_HI] & ~shift_q[`BDC_SUB_ADDR_LO];
  wire cmd_good = eos & frame_ok;
  wire ack_start = cmd_good & shift_q[`BDC_ACK_REQ_POS] & cfg_ack_en_q;

  // Reference selection
  wire [4:0] tgt = sw_mode_q ? step_q : `BDC_FULL_CODE;
  wire [4:0] code_w = ss_active && (ramp_q[4:0] < tgt) ? ramp_q[4:0] : tgt;

  // Operating state sequence
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_OFF:
        if (rise)
          st_d = ST_DET;
      ST_DET:
        if (shdn_hit)
          st_d = ST_OFF;
        else if (open_now)
          st_d = ST_FLT;
        else if (det_hit || win_end)
          st_d = ST_RUN;
      ST_RUN:
        if (shdn_hit)
          st_d = ST_OFF;
        else if (open_now)
          st_d = ST_FLT;
      ST_FLT:
        if (shdn_hit)
          st_d = ST_OFF;
      default:
        st_d = ST_OFF;
    endcase
  end

  always_ff @(posedge clk_i)
    if (rst_i)
      st_q <= ST_OFF;
    else
      st_q <= st_d;

  // Low time and pin history; saturate so shutdown fires once
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q <= 1'b0;
      low_cnt_q <= 17'h0;
    end
    else
    begin
      ctrl_q <= ctrl_i;
      if (!line_low)
        low_cnt_q <= 17'h0;
      else if (!shdn_hit)
        low_cnt_q <= low_cnt_q + 17'h1;
    end
  end

  // Mode detection window, restarted on every enable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      win_cnt_q <= 17'h0;
      arm_q <= 1'b0;
      sw_mode_q <= 1'b0;
    end
    else
    begin
      if (enable)
        win_cnt_q <= 17'h0;
      else if (st_q == ST_DET && !win_end)
        win_cnt_q <= win_cnt_q + 17'h1;
      if (st_q != ST_DET || rise)
        arm_q <= 1'b0;
      else if (fall && win_cnt_q >= DLY_CYC)
        arm_q <= 1'b1;
      if (enable)
        sw_mode_q <= 1'b0;
      else if (det_hit)
        sw_mode_q <= 1'b1;
    end
  end

  // Soft-start ramp, one stage per step period
  always_ff @(posedge clk_i)
  begin
    if (rst_i || enable)
    begin
      ss_cnt_q <= 13'h0;
      ramp_q <= 6'h0;
    end
    else if (ss_active)
    begin
      ss_cnt_q <= ss_last ? 13'h0 : ss_cnt_q + 13'h1;
      if (ss_last)
        ramp_q <= ramp_q + 6'h1;
    end
  end

  // Single-wire bit receiver: a bit is a low then a high phase
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !rx_en)
    begin
      hi_cnt_q <= 16'h0;
      lo_cnt_q <= 16'h0;
      have_low_q <= 1'b0;
      nbits_q <= 5'h0;
      shift_q <= 16'h0;
    end
    else if (rise)
    begin
      have_low_q <= 1'b1;
      hi_cnt_q <= 16'h0;
    end
    else if (fall)
    begin
      lo_cnt_q <= 16'h0;
      have_low_q <= 1'b0;
      if (have_low_q)
      begin
        shift_q <= {shift_q[14:0], bit_val};
        nbits_q <= (nbits_q == 5'h1f) ? nbits_q : nbits_q + 5'h1;
      end
    end
    else if (eos || (ctrl_i && hi_cnt_q >= IDLE_CYC))
    begin
      nbits_q <= 5'h0;
      have_low_q <= 1'b0;
    end
    else if (ctrl_i)
      hi_cnt_q <= (&hi_cnt_q) ? hi_cnt_q : hi_cnt_q + 16'h1;
    else
      lo_cnt_q <= (&lo_cnt_q) ? lo_cnt_q : lo_cnt_q + 16'h1;
  end

  // Stored step survives shutdown; only reset returns it to full scale
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      step_q <= `BDC_FULL_CODE;
      last_data_q <= 8'h0;
      cmd_cnt_q <= 8'h0;
    end
    else if (cmd_good)
    begin
      step_q <= shift_q[4:0];
      last_data_q <= shift_q[7:0];
      cmd_cnt_q <= cmd_cnt_q + 8'h1;
    end
  end

  // Acknowledge pull-down of fixed length
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !running)
    begin
      ack_q <= 1'b0;
      ack_cnt_q <= 16'h0;
    end
    else if (ack_start)
    begin
      ack_q <= 1'b1;
      ack_cnt_q <= 16'h0;
    end
    else if (ack_q)
    begin
      ack_cnt_q <= ack_cnt_q + 16'h1;
      if (ack_cnt_q == ACK_CYC - 16'h1)
        ack_q <= 1'b0;
    end
  end

  // Registered analog controls; in duty-cycle mode gate follows the pin each cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pwr_q <= '0;
      ref_q <= '0;
    end
    else
    begin
      pwr_q.gate_en <= running & ~open_now;
      pwr_q.ilim_half <= ss_active;
      pwr_q.ilim_open <= open_now;
      ref_q.gate <= running & (sw_mode_q | ctrl_i);
      ref_q.code <= running ? code_w : 5'h0;
      ref_q.mv <= running ? code_mv(code_w) : 8'h0;
    end
  end

  assign pwr_o = pwr_q;
  assign ref_o = ref_q;
  assign ctrl_o = 1'b0;
  assign ctrl_oe_o = ack_q;

  // Register decode; unmapped offsets read zero
  wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;
  wire hit_status = wb_adr_i == `BDC_REG_STATUS;
  wire hit_cfg = wb_adr_i == `BDC_REG_CFG;
  wire hit_cmd = wb_adr_i == `BDC_REG_CMD;
  wire [31:0] status_w = {8'h0, ref_q.mv, 3'h0, step_q, 1'b0,
                          st_q == ST_FLT, ss_active, sw_mode_q, st_q};
  wire [31:0] cfg_w = {31'h0, cfg_ack_en_q};
  wire [31:0] cmd_w = {16'h0, cmd_cnt_q, last_data_q};
  wire [31:0] rd_w = hit_status ? status_w : hit_cfg ? cfg_w : hit_cmd ? cmd_w : 32'h0;

  // Bus slave answers one cycle after the request
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_q <= 1'b0;
      wb_dat_q <= 32'h0;
      cfg_ack_en_q <= `BDC_CFG_ACK_EN_RST;
    end
    else
    begin
      wb_ack_q <= wb_req;
      if (wb_req && !wb_we_i)
        wb_dat_q <= rd_w;
      if (wb_req && wb_we_i && hit_cfg && wb_sel_i[0])
        cfg_ack_en_q <= wb_dat_i[`BDC_CFG_ACK_EN_POS];
    end
  end

  assign wb_ack_o = wb_ack_q;
  assign wb_dat_o = wb_dat_q;

  // Checks on the control sequence
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_enable;
    (st_q == ST_OFF) && rise;
  endsequence

  sequence s_leave_on;
    (st_q != ST_OFF) ##1 (st_q == ST_OFF);
  endsequence

  a_ramp_hold: assert property (ss_active && !ss_last |=> $stable(ramp_q))
    else $error("ramp moved before its stage ended");
  a_ramp_adv: assert property (ss_active && ss_last |=> ramp_q == $past(ramp_q) + 6'h1)
    else $error("ramp failed to advance");
  a_half_limit: assert property (ss_active |=> pwr_o.ilim_half)
    else $error("current limit not halved in ramp");
  a_open_trip: assert property (running && open_now |=> st_q == ST_FLT ##1 !pwr_o.gate_en)
    else $error("open string did not shut down");
  a_open_limit: assert property (open_now |=> pwr_o.ilim_open)
    else $error("open limit not selected");
  a_fault_hold: assert property ((st_q == ST_FLT) && !shdn_hit |=> st_q == ST_FLT)
    else $error("fault released early");
  a_off_cause: assert property (s_leave_on |-> $past(low_cnt_q) == SHDN_CYC)
    else $error("shutdown without long low");
  a_gate_off: assert property (!running |=> !pwr_o.gate_en)
    else $error("gate active in shutdown");
  a_enable_mode: assert property (s_enable |=> st_q == ST_DET && !sw_mode_q && ramp_q == 6'h0)
    else $error("enable did not start detection");
  a_mode_fixed: assert property ((st_q == ST_RUN) ##1 (st_q == ST_RUN) |-> $stable(sw_mode_q))
    else $error("mode changed while running");
  a_pwm_gate: assert property (running && !sw_mode_q |=> ref_o.gate == $past(ctrl_i))
    else $error("reference gate not following pin");
  a_step_cause: assert property ($changed(step_q) |-> $past(cmd_good))
    else $error("step changed without valid command");
  a_ack_cause: assert property ($rose(ack_q) |-> $past(cmd_good && shift_q[7]))
    else $error("acknowledge without request");
endmodule : bdc_top
